// file: arith_flag_pkg.sv
// Package of constants, types and register map for the condition-flag unit
package arith_flag_pkg;

   // ------------------------------------------------------------------
   // Flag bit addresses in the controller's bit map
   // ------------------------------------------------------------------
   localparam int unsigned BITADDR_OPERAND_ERROR = 25503;
   localparam int unsigned BITADDR_CARRY         = 25504;
   localparam int unsigned BITADDR_GREATER       = 25505;
   localparam int unsigned BITADDR_EQUAL         = 25506;
   localparam int unsigned BITADDR_LESS          = 25507;
   localparam int unsigned BITADDR_NEGATIVE      = 25402;

   // Function code of the end-of-program instruction
   localparam logic [7:0] END_FUNC_CODE = 8'h01;

   // ------------------------------------------------------------------
   // Bit positions of the flags in the flag register
   // ------------------------------------------------------------------
   localparam int FPOS_OPERAND_ERROR = 3;
   localparam int FPOS_CARRY         = 4;
   localparam int FPOS_GREATER       = 5;
   localparam int FPOS_EQUAL         = 6;
   localparam int FPOS_LESS          = 7;
   localparam int FPOS_NEGATIVE      = 18;

   // ------------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------------
   localparam int AXI_ADDR_W = 8;
   localparam logic [AXI_ADDR_W-1:0] OFS_FLAGS  = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] OFS_MASK   = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] OFS_CTRL   = 8'h0C;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Status and mask layout
   localparam int STAT_W            = 3;
   localparam int SPOS_ERROR_RAISED = 0;
   localparam int SPOS_SKIPPED      = 1;
   localparam int SPOS_END_SEEN     = 2;
   localparam logic [STAT_W-1:0] STATUS_RESET = 3'h0;
   localparam logic [STAT_W-1:0] MASK_RESET   = 3'h0;

   // Control layout
   localparam int CPOS_ENABLE = 0;
   localparam int CPOS_CLEAR  = 1;
   localparam logic CTRL_ENABLE_RESET = 1'b1;

   // Edge-memory slots
   localparam int SLOT_W     = 8;
   localparam int SLOT_COUNT = 256;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      CL_NONE         = 4'h0,
      CL_LADDER       = 4'h1,
      CL_TIMER        = 4'h2,
      CL_COUNTER      = 4'h3,
      CL_END          = 4'h4,
      CL_COMPARE      = 4'h5,
      CL_ARITH        = 4'h6,
      CL_SET_CARRY    = 4'h7,
      CL_CLR_CARRY    = 4'h8,
      CL_ERR_ONLY     = 4'h9,
      CL_RANGE_WORD   = 4'hA,
      CL_RANGE_DOUBLE = 4'hB
   } instr_class_e;

   typedef enum logic [1:0] {
      EDGE_LEVEL = 2'h0,
      EDGE_RISE  = 2'h1,
      EDGE_FALL  = 2'h2
   } edge_mode_e;

   typedef struct packed {
      logic              operandErrorFlag;
      logic              carryFlag;
      logic              greaterThanFlag;
      logic              equalFlag;
      logic              lessThanFlag;
      logic              negativeFlag;
   } flag_s;

   localparam flag_s FLAGS_CLEAR = '{default: 1'b0};

   typedef struct packed {
      logic              valid;
      instr_class_e      iclass;
      edge_mode_e        edgeMode;
      logic              execCond;
      logic [SLOT_W-1:0] slot;
      logic              opError;
      logic              carryOut;
      logic              resultZero;
      logic              resultNeg;
      logic [31:0]       valA;
      logic [31:0]       valB;
      logic [31:0]       valC;
   } instr_step_s;

endpackage

// file: range_compare.sv
// Range comparator for the single- and double-word range-compare instructions
`timescale 1ns/10ps
module range_compare (
   input  wire logic [31:0] value,
   input  wire logic [31:0] lower,
   input  wire logic [31:0] upper,
   input  wire logic        isDouble,
   output logic             greater,
   output logic             equal,
   output logic             less,
   output logic             limitError
);
   import arith_flag_pkg::*;

   logic [31:0] v;
   logic [31:0] lo;
   logic [31:0] hi;

   // ------------------------------------------------------------------
   // Word form looks at the low 16 bits only
   // ------------------------------------------------------------------
   always_comb begin
      v  = isDouble ? value : {16'h0000, value[15:0]};
      lo = isDouble ? lower : {16'h0000, lower[15:0]};
      hi = isDouble ? upper : {16'h0000, upper[15:0]};
      // A lower limit above the upper one has no meaning
      limitError = lo > hi;
      greater    = v > hi;
      less       = v < lo;
      equal      = !greater && !less;
   end

endmodule

// file: arith_flag_update.sv
// Condition-flag unit of the instruction processor with an AXI4-Lite register slave
`timescale 1ns/10ps

// Summary of operation
// RULE_01: Operand data outside permitted limits sets the operand error flag.
// RULE_02: Carry flag reports carry or shifted-out results of arithmetic and shifts.
// RULE_03: Compare sets greater, less or equal from value against reference.
// RULE_04: Arithmetic instructions set the equal flag when the result is zero.
// RULE_05: Result-dependent flags are driven both on and off by the outcome.
// RULE_06: With error set, ladder, timer, counter run; other error-dependent ones skip.
// RULE_07: With error set, carry, greater, equal, less, negative stay untouched.
// RULE_08: Instructions not affecting flags leave all six flags unchanged.
// RULE_09: Edge-triggered forms update flags exactly like level forms.
// RULE_10: End-of-program instruction, code 01, clears all six flags.
// RULE_11: Each executed flag instruction overwrites its flags; latest one wins.
// RULE_12: Edge-triggered instruction runs once per qualifying edge of its condition.
// RULE_13: When an edge instruction does not run, flags keep their last values.
// RULE_14: Word range compare reports against lower and upper limit on three flags.
// RULE_15: Double range compare does the same for an 8-digit value.
// RULE_16: A negative flag is the sixth flag, updated per instruction.
// RULE_17: All six flags reset to zero.
module arith_flag_update #(
   parameter int SLOTS = arith_flag_pkg::SLOT_COUNT
) (
   input  wire logic                                  clk,
   input  wire logic                                  reset_n,
   input  wire arith_flag_pkg::instr_step_s           step,
   output arith_flag_pkg::flag_s                      flags,
   output logic                                       executed,
   output logic                                       skipped,
   output logic                                       irq,
   input  wire logic [arith_flag_pkg::AXI_ADDR_W-1:0] awaddr,
   input  wire logic [2:0]                            awprot,
   input  wire logic                                  awvalid,
   output logic                                       awready,
   input  wire logic [31:0]                           wdata,
   input  wire logic [3:0]                            wstrb,
   input  wire logic                                  wvalid,
   output logic                                       wready,
   output logic [1:0]                                 bresp,
   output logic                                       bvalid,
   input  wire logic                                  bready,
   input  wire logic [arith_flag_pkg::AXI_ADDR_W-1:0] araddr,
   input  wire logic [2:0]                            arprot,
   input  wire logic                                  arvalid,
   output logic                                       arready,
   output logic [31:0]                                rdata,
   output logic [1:0]                                 rresp,
   output logic                                       rvalid,
   input  wire logic                                  rready
);
   import arith_flag_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   flag_s                   flags_q;
   flag_s                   flags_d;
   logic                    executed_q;
   logic                    executed_d;
   logic                    skipped_q;
   logic                    skipped_d;
   logic                    condMem_q [SLOTS];
   logic                    memWe;
   logic                    fire;
   logic                    prevCond;
   logic                    endSeen;
   logic                    rangeGreater;
   logic                    rangeEqual;
   logic                    rangeLess;
   logic                    rangeLimitErr;
   logic                    newError;
   logic [STAT_W-1:0]       status_q;
   logic [STAT_W-1:0]       status_d;
   logic [STAT_W-1:0]       mask_q;
   logic [STAT_W-1:0]       mask_d;
   logic [STAT_W-1:0]       events;
   logic [STAT_W-1:0]       w1c;
   logic                    ctrlEnable_q;
   logic                    ctrlEnable_d;
   logic                    swClear;
   logic                    awHeld_q;
   logic                    awHeld_d;
   logic                    wHeld_q;
   logic                    wHeld_d;
   logic [AXI_ADDR_W-1:0]   awAddr_q;
   logic [AXI_ADDR_W-1:0]   awAddr_d;
   logic [31:0]             wData_q;
   logic [31:0]             wData_d;
   logic [3:0]              wStrb_q;
   logic [3:0]              wStrb_d;
   logic                    bvalid_q;
   logic                    bvalid_d;
   logic [1:0]              bresp_q;
   logic [1:0]              bresp_d;
   logic                    rvalid_q;
   logic                    rvalid_d;
   logic [31:0]             rdata_q;
   logic [31:0]             rdata_d;
   logic [1:0]              rresp_q;
   logic [1:0]              rresp_d;
   logic                    doWrite;
   logic [31:0]             merged;
   logic [31:0]             flagWord;

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Range comparison for both range-compare forms
   // ------------------------------------------------------------------
   range_compare u_range (
      .value      (step.valA),
      .lower      (step.valB),
      .upper      (step.valC),
      .isDouble   (step.iclass == CL_RANGE_DOUBLE),
      .greater    (rangeGreater),
      .equal      (rangeEqual),
      .less       (rangeLess),
      .limitError (rangeLimitErr)
   );

   // ------------------------------------------------------------------
   // Execution decision and flag update
   // ------------------------------------------------------------------
   always_comb begin
      flags_d    = flags_q;
      executed_d = 1'b0;
      skipped_d  = 1'b0;
      endSeen    = 1'b0;
      newError   = 1'b0;
      prevCond   = condMem_q[step.slot];
      memWe      = 1'b0;
      fire       = 1'b0;
      if (step.valid && ctrlEnable_q) begin
         // Remembering the condition every step, fired or not, is what
         // keeps an edge instruction from running twice on one level
         memWe = step.edgeMode != EDGE_LEVEL;
         case (step.edgeMode)
            EDGE_RISE: begin
               fire = step.execCond && !prevCond; // [RULE_12]
            end
            EDGE_FALL: begin
               fire = !step.execCond && prevCond; // [RULE_12]
            end
            default: begin
               fire = step.execCond;
            end
         endcase
         if (step.iclass == CL_END) begin
            flags_d    = FLAGS_CLEAR; // [RULE_10]
            executed_d = 1'b1;
            endSeen    = 1'b1;
         end else if (fire) begin
            // Same update whatever the edge mode [RULE_09]
            case (step.iclass)
               CL_NONE, CL_LADDER: begin
                  executed_d = 1'b1; // [RULE_08] [RULE_06]
               end
               CL_TIMER, CL_COUNTER: begin
                  executed_d = 1'b1; // [RULE_06]
                  flags_d.operandErrorFlag = step.opError; // [RULE_01] [RULE_05]
               end
               CL_SET_CARRY, CL_CLR_CARRY: begin
                  executed_d = 1'b1;
                  if (!flags_q.operandErrorFlag) begin // [RULE_07]
                     flags_d.carryFlag = step.iclass == CL_SET_CARRY; // [RULE_02]
                  end
               end
               default: begin
                  if (flags_q.operandErrorFlag) begin
                     skipped_d = 1'b1; // [RULE_06] [RULE_07]
                  end else begin
                     executed_d = 1'b1;
                     newError   = step.opError;
                     if ((step.iclass == CL_RANGE_WORD) ||
                         (step.iclass == CL_RANGE_DOUBLE)) begin
                        newError = step.opError || rangeLimitErr;
                     end
                     flags_d.operandErrorFlag = newError; // [RULE_01] [RULE_11]
                     // On an operand error the other flags keep their values
                     if (!newError) begin
                        case (step.iclass)
                           CL_COMPARE: begin
                              flags_d.greaterThanFlag = step.valA > step.valB; // [RULE_03]
                              flags_d.lessThanFlag    = step.valA < step.valB; // [RULE_03]
                              flags_d.equalFlag       = step.valA == step.valB; // [RULE_05]
                           end
                           CL_ARITH: begin
                              flags_d.carryFlag    = step.carryOut; // [RULE_02]
                              flags_d.equalFlag    = step.resultZero; // [RULE_04]
                              flags_d.negativeFlag = step.resultNeg; // [RULE_16]
                           end
                           CL_RANGE_WORD, CL_RANGE_DOUBLE: begin
                              flags_d.greaterThanFlag = rangeGreater; // [RULE_14] [RULE_15]
                              flags_d.equalFlag       = rangeEqual; // [RULE_14] [RULE_15]
                              flags_d.lessThanFlag    = rangeLess; // [RULE_14] [RULE_15]
                           end
                           default: begin
                              flags_d = flags_d;
                           end
                        endcase
                     end
                  end
               end
            endcase
         end
         // No fire leaves flags_d at flags_q, except CL_END, which clears them without a fire [RULE_13]
      end
      if (swClear) begin
         flags_d = FLAGS_CLEAR;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q    <= FLAGS_CLEAR; // [RULE_17]
         executed_q <= 1'b0;
         skipped_q  <= 1'b0;
      end else begin
         flags_q    <= flags_d;
         executed_q <= executed_d;
         skipped_q  <= skipped_d;
      end
   end

   // Previous execution condition of each edge-triggered slot
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < SLOTS; i++) begin
            condMem_q[i] <= 1'b0;
         end
      end else if (memWe) begin
         condMem_q[step.slot] <= step.execCond; // [RULE_12]
      end
   end

   assign flags    = flags_q;
   assign executed = executed_q;
   assign skipped  = skipped_q;

   // ------------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ------------------------------------------------------------------
   assign awready = !awHeld_q && !bvalid_q;
   assign wready  = !wHeld_q && !bvalid_q;
   assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
   assign merged  = mergeStrb(32'h0000_0000, wData_q, wStrb_q);
   assign swClear = doWrite && (awAddr_q == OFS_CTRL) && wStrb_q[0] && wData_q[CPOS_CLEAR];

   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d  = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d  = wData_q;
      wStrb_d  = wStrb_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      if (awvalid && awready) begin
         awHeld_d = 1'b1;
         awAddr_d = awaddr;
      end
      if (wvalid && wready) begin
         wHeld_d = 1'b1;
         wData_d = wdata;
         wStrb_d = wstrb;
      end
      if (doWrite) begin
         awHeld_d = 1'b0;
         wHeld_d  = 1'b0;
         bvalid_d = 1'b1;
         case (awAddr_q)
            OFS_FLAGS, OFS_STATUS, OFS_MASK, OFS_CTRL: begin
               bresp_d = RESP_OKAY;
            end
            default: begin
               bresp_d = RESP_SLVERR;
            end
         endcase
      end else if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= '0;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q  <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q  <= wData_d;
         wStrb_q  <= wStrb_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp  = bresp_q;

   // ------------------------------------------------------------------
   // Status, mask, control and interrupt
   // ------------------------------------------------------------------
   assign events[SPOS_ERROR_RAISED] = !flags_q.operandErrorFlag && flags_d.operandErrorFlag;
   assign events[SPOS_SKIPPED]      = skipped_d;
   assign events[SPOS_END_SEEN]     = endSeen;
   assign w1c = (doWrite && (awAddr_q == OFS_STATUS)) ? merged[STAT_W-1:0] : '0;

   always_comb begin
      // Set wins over a clear in the same cycle so no event is lost
      status_d     = (status_q & ~w1c) | events;
      mask_d       = mask_q;
      ctrlEnable_d = ctrlEnable_q;
      if (doWrite && (awAddr_q == OFS_MASK) && wStrb_q[0]) begin
         mask_d = wData_q[STAT_W-1:0];
      end
      if (doWrite && (awAddr_q == OFS_CTRL) && wStrb_q[0]) begin
         ctrlEnable_d = wData_q[CPOS_ENABLE];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q     <= STATUS_RESET;
         mask_q       <= MASK_RESET;
         ctrlEnable_q <= CTRL_ENABLE_RESET;
      end else begin
         status_q     <= status_d;
         mask_q       <= mask_d;
         ctrlEnable_q <= ctrlEnable_d;
      end
   end

   assign irq = |(status_q & mask_q);

   // ------------------------------------------------------------------
   // Read channel: one read at a time, answer one cycle after address
   // ------------------------------------------------------------------
   always_comb begin
      flagWord = 32'h0000_0000;
      flagWord[FPOS_OPERAND_ERROR] = flags_q.operandErrorFlag;
      flagWord[FPOS_CARRY]         = flags_q.carryFlag;
      flagWord[FPOS_GREATER]       = flags_q.greaterThanFlag;
      flagWord[FPOS_EQUAL]         = flags_q.equalFlag;
      flagWord[FPOS_LESS]          = flags_q.lessThanFlag;
      flagWord[FPOS_NEGATIVE]      = flags_q.negativeFlag;
   end

   assign arready = !rvalid_q;

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (araddr)
            OFS_FLAGS: begin
               rdata_d = flagWord;
            end
            OFS_STATUS: begin
               rdata_d = {{(32-STAT_W){1'b0}}, status_q};
            end
            OFS_MASK: begin
               rdata_d = {{(32-STAT_W){1'b0}}, mask_q};
            end
            OFS_CTRL: begin
               rdata_d = {31'h0000_0000, ctrlEnable_q};
            end
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   assign rvalid = rvalid_q;
   assign rdata  = rdata_q;
   assign rresp  = rresp_q;

endmodule

// file: arith_flag_checker.sv
// Port-level assertions for the condition-flag unit
`timescale 1ns/10ps
module arith_flag_checker (
   input wire logic                        clk,
   input wire logic                        reset_n,
   input wire arith_flag_pkg::instr_step_s step,
   input wire arith_flag_pkg::flag_s       flags,
   input wire logic                        executed,
   input wire logic                        skipped
);
   import arith_flag_pkg::*;
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ok picks fired level steps with no error pending or raised; only these get the result checks
   wire logic ok = step.valid && step.edgeMode == EDGE_LEVEL && step.execCond
                   && !flags.operandErrorFlag && !step.opError;
   chk_end_clears: assert property (step.valid && step.iclass == CL_END
      |=> flags == FLAGS_CLEAR) else $error("flags kept after end");
   chk_err_blocks: assert property (step.valid && flags.operandErrorFlag
      && step.execCond && step.edgeMode == EDGE_LEVEL
      && step.iclass == CL_COMPARE |=> $stable(flags) && skipped && !executed)
      else $error("compare ran while error set");
   chk_arith_result: assert property (ok && step.iclass == CL_ARITH
      |=> flags.equalFlag == $past(step.resultZero) && flags.carryFlag == $past(step.carryOut)
      && flags.negativeFlag == $past(step.resultNeg)) else $error("arith flags wrong");
   chk_cmp_order: assert property (ok && step.iclass == CL_COMPARE
      |=> flags.greaterThanFlag == ($past(step.valA) > $past(step.valB))
      && flags.lessThanFlag == ($past(step.valA) < $past(step.valB))) else $error("compare wrong");
   chk_timer_err: assert property (step.valid && step.iclass == CL_TIMER
      && step.edgeMode == EDGE_LEVEL && step.execCond
      |=> flags.operandErrorFlag == $past(step.opError)) else $error("timer error wrong");
   chk_plain_keep: assert property (step.valid && step.iclass == CL_LADDER
      && step.execCond && step.edgeMode == EDGE_LEVEL
      |=> $stable(flags) && executed) else $error("ladder changed flags");
   chk_edge_idle: assert property (step.valid && step.edgeMode == EDGE_RISE
      && !step.execCond && step.iclass != CL_END |=> $stable(flags) && !executed)
      else $error("idle edge step ran");
   chk_reset_clear: assert property ($rose(reset_n) |-> flags == FLAGS_CLEAR)
      else $error("flags not clear after reset");
endmodule

// file: arith_flag_update_test.sv
// Self-checking bench for the condition-flag unit
`timescale 1ns/10ps
module arith_flag_update_test;
   import arith_flag_pkg::*;
   // ------------------------------------------------------------------
   // Stimulus, tasks and sequence
   // ------------------------------------------------------------------
   logic        clk = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, executed, skipped, irq;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   instr_step_s step = '0;
   flag_s       flags;
   int          n_errors = 0, checks_done = 0;
   always #10 clk = ~clk;
   arith_flag_update uut (.clk(clk), .reset_n(reset_n), .step(step), .flags(flags),
      .executed(executed), .skipped(skipped), .irq(irq), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   task end_of_test;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Expected e is {executed, skipped, error, carry, greater, equal, less, negative}
   task st(input instr_class_e c, input edge_mode_e m, input logic [8:0] cs,
           input logic [3:0] r, input logic [31:0] a, b, u, input logic [7:0] e);
      @(posedge clk);
      step <= '{1'b1, c, m, cs[8], cs[7:0], r[3], r[2], r[1], r[0], a, b, u};
      @(posedge clk);
      step.valid <= 1'b0;
      #1 chk({executed, skipped, flags}, e);
   endtask
   // Mid-cycle values hold until the next edge
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa, pw, pb;
      int   i;
      @(posedge clk);
      if (w) begin
         awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      end else begin
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      end
      pb = 1'b1;
      for (i = 0; i < 40 && pb; i++) begin
         @(negedge clk);
         pa = w ? awready && awvalid : arready && arvalid;
         pw = wready && wvalid;
         pb = !(w ? bvalid : rvalid);
         if (!pb) chk(w ? bresp : rresp, er);
         if (!pb && !w) chk(rdata, d);
         @(posedge clk);
         if (pa) begin awvalid <= 1'b0; arvalid <= 1'b0; end
         if (pw) wvalid <= 1'b0;
         if (!pb) begin bready <= 1'b0; rready <= 1'b0; end
      end
      if (pb) begin n_errors++; end_of_test; end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      #1 chk(flags, 6'h00);
      acc(0, OFS_MASK, 32'h0, RESP_OKAY);
      st(CL_ARITH, EDGE_LEVEL, 9'h100, 4'h7, 0, 0, 0, 8'h95);
      st(CL_ARITH, EDGE_LEVEL, 9'h100, 4'h0, 0, 0, 0, 8'h80);
      for (int k = 0; k < 3; k++) st(CL_COMPARE, EDGE_LEVEL, 9'h100, 4'h0, 5 - k, 4, 0,
         8'h80 | (8'h08 >> k));
      // Upper half set: a full-width compare would call this greater
      st(CL_RANGE_WORD, EDGE_LEVEL, 9'h100, 4'h0, 32'h10005, 6, 10, 8'h82);
      st(CL_RANGE_DOUBLE, EDGE_LEVEL, 9'h100, 4'h0, 32'h10005, 6, 32'h20000, 8'h84);
      st(CL_RANGE_DOUBLE, EDGE_LEVEL, 9'h100, 4'h0, 5, 9, 3, 8'hA4);
      st(CL_COMPARE, EDGE_LEVEL, 9'h100, 4'h0, 9, 1, 0, 8'h64);
      st(CL_ARITH, EDGE_LEVEL, 9'h100, 4'h6, 0, 0, 0, 8'h64);
      st(CL_LADDER, EDGE_LEVEL, 9'h100, 4'h0, 0, 0, 0, 8'hA4);
      st(CL_TIMER, EDGE_LEVEL, 9'h100, 4'h0, 0, 0, 0, 8'h84);
      st(CL_ARITH, EDGE_RISE, 9'h005, 4'h4, 0, 0, 0, 8'h04);
      st(CL_ARITH, EDGE_RISE, 9'h105, 4'h4, 0, 0, 0, 8'h90);
      st(CL_ARITH, EDGE_RISE, 9'h105, 4'h2, 0, 0, 0, 8'h10);
      st(CL_ARITH, EDGE_FALL, 9'h106, 4'h2, 0, 0, 0, 8'h10);
      st(CL_ARITH, EDGE_FALL, 9'h006, 4'h2, 0, 0, 0, 8'h84);
      acc(0, OFS_FLAGS, 32'h40, RESP_OKAY);
      acc(1, OFS_CTRL, 32'h3, RESP_OKAY);
      #1 chk(flags, 6'h00);
      st(CL_SET_CARRY, EDGE_LEVEL, 9'h100, 4'h0, 0, 0, 0, 8'h90);
      st(CL_END, EDGE_LEVEL, 9'h000, 4'h7, 0, 0, 0, 8'h80);
      acc(1, OFS_MASK, 32'h4, RESP_OKAY);
      #1 chk(irq, 1'b1);
      acc(0, OFS_STATUS, 32'h7, RESP_OKAY);
      acc(1, OFS_STATUS, 32'h4, RESP_OKAY);
      #1 chk(irq, 1'b0);
      acc(0, OFS_STATUS, 32'h3, RESP_OKAY);
      acc(0, 8'h10, 32'h0, RESP_SLVERR);
      acc(1, 8'h10, 32'h0, RESP_SLVERR);
      end_of_test;
   end
   initial begin
      #200000;
      n_errors++;
      end_of_test;
   end
endmodule
bind arith_flag_update arith_flag_checker chk_i (.clk(clk), .reset_n(reset_n), .step(step),
   .flags(flags), .executed(executed), .skipped(skipped));
